/* File: asc_config.sv */
// Summary of operation
// - Byte 01xxxxxx writes six setup bits.
// - Clock mode high bit resets to one.
// - Clock mode bits pick one of four.
// - Reference bits pick one of four settings.
// - Pair select 0x: no data byte follows.
// - Pair select 10: next byte is unipolar.
// - Pair select 11: next byte is bipolar.
// - Unipolar bit 7 covers inputs 0,1 downward.
// - Bipolar bit 7 covers inputs 0,1 downward.
// - Byte 001xxxxx writes five averaging bits.
// - Averaging bit 4 switches averaging on except in clock mode 11.
// - Count bits choose 4, 8, 16, 32.
// - Repeat bits give 4 to 16 results.
// - Byte 0001xxxx is reset, bits 2:0 ignored.
// - Bit 3 zero resets all, one clears FIFO.
// - Result frame is four zeros, twelve bits.
// - Input bits captured on rising SCLK.
// - Output bits change on falling SCLK.
// - Modes 00, 01 start from pin only.
// - Modes 10, 11 start from conversion byte.
// - Unipolar straight binary, bipolar two's complement.
// - Temperature is diode difference minus offset.
// - Byte 1xxxxxxx is a conversion command.
// - Pair in both registers counts as unipolar.
// - All other registers reset to zero.
module asc_config
    import asc_pkg::*;
#(
    parameter int SLOTS = 4,
    parameter logic [11:0] TEMP_OFFSET = 12'h000
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT,
    input wire logic CONVERT_START_PIN_N,
    input wire logic [11:0] SAMPLE,
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_BIPOLAR,
    input wire logic SAMPLE_TEMP,
    output logic RESULT_PENDING,
    output logic [1:0] CLOCK_MODE,
    output logic [1:0] VREF_MODE,
    output logic START_PIN_FREE,
    output logic ACQ_BY_PIN,
    output logic SCLK_CONVERSION,
    output logic REF_NEEDS_WAKEUP,
    output logic REF_ALWAYS_ON,
    output logic REF_EXTERNAL,
    output logic NEG_REF_PIN_CLAIMED,
    output logic [7:0] UNI_PAIR_ENABLE,
    output logic [7:0] BI_PAIR_ENABLE,
    output logic [7:0] BI_PAIR_EFFECTIVE,
    output logic AVERAGE_ENABLE,
    output logic [5:0] AVG_CONVERSIONS,
    output logic [4:0] REPEAT_RESULTS,
    output logic [3:0] CONV_CHANNEL,
    output logic [1:0] CONV_SCAN,
    output logic CONV_TEMP,
    output logic CONV_START,
    output logic FIFO_CLEAR
);

    localparam int IW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

    // ---------------------------------------------------------------
    // Command decode
    // ---------------------------------------------------------------
    function automatic asc_cmd_e decode(input logic [7:0] b,
                                        input asc_pend_e pend,
                                        input logic first);
        asc_cmd_e c;
        c = CMD_NOP;
        if (pend != PEND_NONE && !first) begin
            c = CMD_PAIR;
        end else if (b[CMD_BIT_CONV]) begin
            c = CMD_CONV;
        end else if (b[CMD_BIT_SETUP]) begin
            c = CMD_SETUP;
        end else if (b[CMD_BIT_AVG]) begin
            c = CMD_AVG;
        end else if (b[CMD_BIT_RESET]) begin
            c = CMD_RESET;
        end
        return c;
    endfunction : decode

    // ---------------------------------------------------------------
    // Link domain: byte capture
    // ---------------------------------------------------------------
    // Bytes land in a ring of slots, each with its own toggle, so the
    // system side always reads a slot that is no longer being written.
    // The ring depth bounds how far the system side may lag the link.
    logic [2:0] bit_cnt;
    logic [6:0] in_shift;
    logic frame_first;
    logic [IW-1:0] wr_idx;
    logic [7:0] slot_data [SLOTS];
    logic [SLOTS-1:0] slot_first;
    logic [SLOTS-1:0] slot_tog;

    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            bit_cnt <= '0;
            in_shift <= '0;
            frame_first <= 1'b1;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            in_shift <= {in_shift[5:0], DIN};
            if (bit_cnt == BITS_PER_BYTE_LAST) begin
                frame_first <= 1'b0;
            end
        end
    end

    always_ff @(posedge SCLK or posedge RST) begin
        if (RST) begin
            wr_idx <= '0;
            slot_tog <= '0;
            slot_first <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                slot_data[i] <= '0;
            end
        end else if (!CS_N && bit_cnt == BITS_PER_BYTE_LAST) begin
            slot_data[wr_idx] <= {in_shift, DIN};
            slot_first[wr_idx] <= frame_first;
            slot_tog[wr_idx] <= ~slot_tog[wr_idx];
            wr_idx <= (wr_idx == IW'(SLOTS - 1)) ? '0 : wr_idx + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Link domain: result shift-out
    // ---------------------------------------------------------------
    // The first frame bit is a leading zero, so DOUT is already correct
    // while select is high and before the first falling edge.
    logic [11:0] result_hold;
    logic [15:0] out_frame;
    logic [4:0] out_cnt;

    assign out_frame = {4'h0, result_hold};

    always_ff @(negedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            out_cnt <= '0;
            DOUT <= 1'b0;
        end else if (out_cnt < OUT_FRAME_LAST) begin
            out_cnt <= out_cnt + 5'h01;
            DOUT <= out_frame[4'(OUT_FRAME_LAST - 5'h01 - out_cnt)];
        end else begin
            DOUT <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Crossing into the system clock
    // ---------------------------------------------------------------
    logic [SLOTS+1:0] sync_out;
    logic [SLOTS-1:0] tog_sync;
    logic cs_idle;
    logic pin_low_sync;
    logic pin_low_prev;
    logic [SLOTS-1:0] seen;
    logic [IW-1:0] rd_idx;
    logic new_byte;
    logic [7:0] cmd_byte;
    logic cmd_first;

    asc_sync #(
        .WIDTH(SLOTS + 2)
    ) u_sync (
        .clk(MCLK),
        .rst(RST),
        .d({~CONVERT_START_PIN_N, ~CS_N, slot_tog}),
        .q(sync_out)
    );

    assign tog_sync = sync_out[SLOTS-1:0];
    assign cs_idle = !sync_out[SLOTS];
    assign pin_low_sync = sync_out[SLOTS+1];
    assign new_byte = tog_sync[rd_idx] != seen[rd_idx];
    assign cmd_byte = slot_data[rd_idx];
    assign cmd_first = slot_first[rd_idx];

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            seen <= '0;
            rd_idx <= '0;
        end else if (new_byte) begin
            seen[rd_idx] <= ~seen[rd_idx];
            rd_idx <= (rd_idx == IW'(SLOTS - 1)) ? '0 : rd_idx + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    asc_pend_e pend;
    asc_cmd_e cmd;
    logic reg_reset;
    logic [5:0] setup_config;
    logic [4:0] averaging_config;
    logic [7:0] conv_config;

    assign cmd = new_byte ? decode(cmd_byte, pend, cmd_first) : CMD_NOP;
    assign reg_reset = cmd == CMD_RESET
        && !cmd_byte[RESET_BIT_FIFO_ONLY];

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pend <= PEND_NONE;
        end else if (new_byte) begin
            if (cmd == CMD_SETUP && cmd_byte[SETUP_BIT_PAIR_SEL_HI]) begin
                pend <= cmd_byte[SETUP_BIT_PAIR_SEL_LO]
                    ? PEND_BI : PEND_UNI;
            end else begin
                pend <= PEND_NONE;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            setup_config <= SETUP_RESET;
        end else if (reg_reset) begin
            setup_config <= SETUP_RESET;
        end else if (cmd == CMD_SETUP) begin
            setup_config <= cmd_byte[5:0];
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            UNI_PAIR_ENABLE <= PAIR_RESET;
        end else if (reg_reset) begin
            UNI_PAIR_ENABLE <= PAIR_RESET;
        end else if (cmd == CMD_PAIR && pend == PEND_UNI) begin
            UNI_PAIR_ENABLE <= cmd_byte;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            BI_PAIR_ENABLE <= PAIR_RESET;
        end else if (reg_reset) begin
            BI_PAIR_ENABLE <= PAIR_RESET;
        end else if (cmd == CMD_PAIR && pend == PEND_BI) begin
            BI_PAIR_ENABLE <= cmd_byte;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            averaging_config <= AVG_RESET;
        end else if (reg_reset) begin
            averaging_config <= AVG_RESET;
        end else if (cmd == CMD_AVG) begin
            averaging_config <= cmd_byte[4:0];
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            conv_config <= CONV_RESET;
        end else if (reg_reset) begin
            conv_config <= CONV_RESET;
        end else if (cmd == CMD_CONV) begin
            conv_config <= cmd_byte;
        end
    end

    // ---------------------------------------------------------------
    // Conversion start and FIFO clear
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pin_low_prev <= 1'b0;
            CONV_START <= 1'b0;
            FIFO_CLEAR <= 1'b0;
        end else begin
            pin_low_prev <= pin_low_sync;
            CONV_START <= (!CLOCK_MODE[1] && pin_low_prev && !pin_low_sync)
                || (CLOCK_MODE[1] && cmd == CMD_CONV);
            FIFO_CLEAR <= cmd == CMD_RESET;
        end
    end

    // ---------------------------------------------------------------
    // Mode outputs
    // ---------------------------------------------------------------
    assign CLOCK_MODE = setup_config[5:4];
    assign VREF_MODE = setup_config[3:2];
    assign START_PIN_FREE = CLOCK_MODE[1];
    assign ACQ_BY_PIN = CLOCK_MODE == CLK_INT_PIN_ACQ;
    assign SCLK_CONVERSION = CLOCK_MODE == CLK_SCLK_SERIAL;
    assign REF_NEEDS_WAKEUP = VREF_MODE == VREF_INT_WAKE;
    assign REF_ALWAYS_ON = VREF_MODE == VREF_INT_ON;
    assign REF_EXTERNAL = VREF_MODE[0];
    assign NEG_REF_PIN_CLAIMED = VREF_MODE == VREF_EXT_DIFF;
    assign BI_PAIR_EFFECTIVE = BI_PAIR_ENABLE & ~UNI_PAIR_ENABLE;
    assign AVERAGE_ENABLE = averaging_config[AVG_BIT_ENABLE];
    assign CONV_CHANNEL = conv_config[6:3];
    assign CONV_SCAN = conv_config[2:1];
    assign CONV_TEMP = conv_config[0];

    // Averaging is meaningless when SCLK itself clocks the conversion.
    always_comb begin
        if (AVERAGE_ENABLE && !SCLK_CONVERSION) begin
            AVG_CONVERSIONS = AVG_BASE << averaging_config[3:2];
        end else begin
            AVG_CONVERSIONS = AVG_ONE;
        end
    end

    always_comb begin
        if (CONV_SCAN == SCAN_REPEAT) begin
            REPEAT_RESULTS = REPEAT_STEP
                * (5'(averaging_config[1:0]) + 5'h01);
        end else begin
            REPEAT_RESULTS = 5'h00;
        end
    end

    // ---------------------------------------------------------------
    // Result formatting
    // ---------------------------------------------------------------
    // The pending result is copied to the link side only while select
    // is seen idle, so the shift-out never samples a changing word.
    logic [11:0] diode_first;
    logic have_first;
    logic [11:0] result_next;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            diode_first <= RESULT_RESET;
            have_first <= 1'b0;
            result_next <= RESULT_RESET;
            RESULT_PENDING <= 1'b0;
        end else begin
            if (SAMPLE_VALID && SAMPLE_TEMP && !have_first) begin
                diode_first <= SAMPLE;
                have_first <= 1'b1;
            end else if (SAMPLE_VALID && SAMPLE_TEMP) begin
                result_next <= diode_first - SAMPLE - TEMP_OFFSET;
                have_first <= 1'b0;
                RESULT_PENDING <= 1'b1;
            end else if (SAMPLE_VALID) begin
                result_next <= SAMPLE_BIPOLAR
                    ? {~SAMPLE[11], SAMPLE[10:0]} : SAMPLE;
                RESULT_PENDING <= 1'b1;
            end else if (cs_idle) begin
                RESULT_PENDING <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            result_hold <= RESULT_RESET;
        end else if (cs_idle && RESULT_PENDING) begin
            result_hold <= result_next;
        end
    end

endmodule : asc_config

/* File: asc_pkg.sv */
package asc_pkg;

    // ---------------------------------------------------------------
    // Command byte layout
    // ---------------------------------------------------------------
    localparam int CMD_BIT_CONV = 7;
    localparam int CMD_BIT_SETUP = 6;
    localparam int CMD_BIT_AVG = 5;
    localparam int CMD_BIT_RESET = 4;
    localparam int RESET_BIT_FIFO_ONLY = 3;
    localparam int SETUP_BIT_PAIR_SEL_HI = 1;
    localparam int SETUP_BIT_PAIR_SEL_LO = 0;
    localparam int AVG_BIT_ENABLE = 4;

    // ---------------------------------------------------------------
    // Values after reset
    // ---------------------------------------------------------------
    localparam logic [5:0] SETUP_RESET = 6'h20;
    localparam logic [4:0] AVG_RESET = 5'h00;
    localparam logic [7:0] PAIR_RESET = 8'h00;
    localparam logic [7:0] CONV_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // ---------------------------------------------------------------
    // Mode encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] CLK_INT_TIMED_PIN = 2'h0;
    localparam logic [1:0] CLK_INT_PIN_ACQ = 2'h1;
    localparam logic [1:0] CLK_INT_SERIAL = 2'h2;
    localparam logic [1:0] CLK_SCLK_SERIAL = 2'h3;
    localparam logic [1:0] VREF_INT_WAKE = 2'h0;
    localparam logic [1:0] VREF_EXT_SINGLE = 2'h1;
    localparam logic [1:0] VREF_INT_ON = 2'h2;
    localparam logic [1:0] VREF_EXT_DIFF = 2'h3;
    localparam logic [1:0] SCAN_REPEAT = 2'h2;

    // ---------------------------------------------------------------
    // Counts
    // ---------------------------------------------------------------
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] BITS_PER_BYTE_LAST = 3'h7;
    localparam logic [4:0] OUT_FRAME_LAST = 5'h0f;
    localparam logic [5:0] AVG_ONE = 6'h01;
    localparam logic [5:0] AVG_BASE = 6'h04;
    localparam logic [4:0] REPEAT_STEP = 5'h04;

    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_CONV,
        CMD_SETUP,
        CMD_AVG,
        CMD_RESET,
        CMD_PAIR
    } asc_cmd_e;

    typedef enum logic [1:0] {
        PEND_NONE,
        PEND_UNI,
        PEND_BI
    } asc_pend_e;

endpackage : asc_pkg

/* File: asc_sync.sv */
module asc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    import asc_pkg::*;

    // ---------------------------------------------------------------
    // Two-stage synchroniser
    // ---------------------------------------------------------------
    // Each bit is an independent level; no bus coherency is implied.
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : asc_sync

/* File: asc_config_asserts.sv */
module asc_config_asserts
    import asc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CS_N,
    input wire logic DOUT,
    input wire logic CONVERT_START_PIN_N,
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_TEMP,
    input wire logic RESULT_PENDING,
    input wire logic [1:0] CLOCK_MODE,
    input wire logic [1:0] VREF_MODE,
    input wire logic START_PIN_FREE,
    input wire logic ACQ_BY_PIN,
    input wire logic SCLK_CONVERSION,
    input wire logic REF_NEEDS_WAKEUP,
    input wire logic REF_ALWAYS_ON,
    input wire logic REF_EXTERNAL,
    input wire logic NEG_REF_PIN_CLAIMED,
    input wire logic [7:0] UNI_PAIR_ENABLE,
    input wire logic [7:0] BI_PAIR_ENABLE,
    input wire logic [7:0] BI_PAIR_EFFECTIVE,
    input wire logic AVERAGE_ENABLE,
    input wire logic [5:0] AVG_CONVERSIONS,
    input wire logic [4:0] REPEAT_RESULTS,
    input wire logic [1:0] CONV_SCAN,
    input wire logic CONV_START,
    input wire logic FIFO_CLEAR
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    property p_ref;
        REF_NEEDS_WAKEUP == (VREF_MODE == VREF_INT_WAKE)
            && REF_ALWAYS_ON == (VREF_MODE == VREF_INT_ON)
            && REF_EXTERNAL == VREF_MODE[0]
            && NEG_REF_PIN_CLAIMED == (VREF_MODE == VREF_EXT_DIFF);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference decode wrong");
    property p_clk;
        START_PIN_FREE == CLOCK_MODE[1]
            && ACQ_BY_PIN == (CLOCK_MODE == CLK_INT_PIN_ACQ)
            && SCLK_CONVERSION == (CLOCK_MODE == CLK_SCLK_SERIAL);
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock mode decode wrong");
    property p_uni_wins;
        BI_PAIR_EFFECTIVE == (BI_PAIR_ENABLE & ~UNI_PAIR_ENABLE);
    endproperty
    a_uni_wins: assert property (p_uni_wins)
        else $error("pair priority");
    property p_avg_off;
        !AVERAGE_ENABLE || CLOCK_MODE == CLK_SCLK_SERIAL
            |-> AVG_CONVERSIONS == AVG_ONE;
    endproperty
    a_avg_off: assert property (p_avg_off)
        else $error("averaging off");
    property p_avg_on;
        AVERAGE_ENABLE && CLOCK_MODE != CLK_SCLK_SERIAL
            |-> AVG_CONVERSIONS inside {6'h04, 6'h08, 6'h10, 6'h20};
    endproperty
    a_avg_on: assert property (p_avg_on)
        else $error("averaging count");
    property p_repeat;
        CONV_SCAN == SCAN_REPEAT ? REPEAT_RESULTS inside {5'h04, 5'h08,
            5'h0c, 5'h10} : REPEAT_RESULTS == 5'h00;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat count");
    property p_pin_start;
        $rose(CONVERT_START_PIN_N) && !CLOCK_MODE[1] |-> ##[1:6] CONV_START;
    endproperty
    a_pin_start: assert property (p_pin_start)
        else $error("pin start");
    property p_start_pulse;
        CONV_START |=> !CONV_START;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start");
    property p_clear_pulse;
        FIFO_CLEAR |=> !FIFO_CLEAR;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("clear");
    property p_dout_idle;
        CS_N && $past(CS_N) |-> !DOUT;
    endproperty
    a_dout_idle: assert property (p_dout_idle) else $error("idle out");
    property p_pending;
        SAMPLE_VALID && !SAMPLE_TEMP |=> RESULT_PENDING;
    endproperty
    a_pending: assert property (p_pending) else $error("no pending");
    c_start: cover property (CONV_START);
    c_clear: cover property (FIFO_CLEAR);
    c_copy: cover property ($fell(RESULT_PENDING));
endmodule : asc_config_asserts

bind asc_config asc_config_asserts chk_u (.*);

/* File: asc_host.sv */
module asc_host (
    output logic SCLK,
    output logic CS_N,
    output logic DIN,
    input wire logic DOUT
);
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // Serial host; the clock stands still low between frames.
    // ---------------------------------------------------------------
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN = 1'b0;
    end
    task bit_io(input logic b, output logic r);
        DIN = b;
        #3 r = DOUT;
        SCLK = 1'b1;
        #3 SCLK = 1'b0;
    endtask : bit_io
    task frame1(input logic [7:0] b);
        logic r;
        CS_N = 1'b0;
        #3;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        #3 CS_N = 1'b1;
        // The line is not held, so a stale level cannot pass for data.
        DIN = ~DIN;
    endtask : frame1
    task frame2(input logic [15:0] w, output logic [15:0] rd);
        logic r;
        CS_N = 1'b0;
        #3;
        for (int i = 15; i >= 0; i--) begin
            bit_io(w[i], r);
            rd = {rd[14:0], r};
        end
        #3 CS_N = 1'b1;
        DIN = ~DIN;
    endtask : frame2
endmodule : asc_host

/* File: asc_config_test.sv */
module asc_config_test
    import asc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] T_OFF = 12'h111;
    logic MCLK = 1'b0, RST = 1'b1, CONVERT_START_PIN_N = 1'b1;
    logic SAMPLE_VALID = 1'b0, SAMPLE_BIPOLAR = 1'b0, SAMPLE_TEMP = 1'b0;
    logic [11:0] SAMPLE = 12'h000;
    logic SCLK, CS_N, DIN, DOUT, RESULT_PENDING, START_PIN_FREE, ACQ_BY_PIN;
    logic SCLK_CONVERSION, REF_NEEDS_WAKEUP, REF_ALWAYS_ON, REF_EXTERNAL;
    logic NEG_REF_PIN_CLAIMED, AVERAGE_ENABLE, CONV_TEMP, CONV_START;
    logic FIFO_CLEAR;
    logic [1:0] CLOCK_MODE, VREF_MODE, CONV_SCAN;
    logic [7:0] UNI_PAIR_ENABLE, BI_PAIR_ENABLE, BI_PAIR_EFFECTIVE;
    logic [5:0] AVG_CONVERSIONS;
    logic [4:0] REPEAT_RESULTS;
    logic [3:0] CONV_CHANNEL;
    int n_fail = 0, checked = 0, n_start = 0, n_clear = 0;
    asc_config #(.TEMP_OFFSET(T_OFF)) dut_u (.*);
    asc_host host_u (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT));
    always #10 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        if (CONV_START === 1'b1) n_start++;
        if (FIFO_CLEAR === 1'b1) n_clear++;
    end
    // ---------------------------------------------------------------
    // Shared tasks and expectations
    // ---------------------------------------------------------------
    task final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : tick
    // Eight cycles cover the synchroniser and decode latency.
    task wr1(input logic [7:0] b);
        host_u.frame1(b);
        tick(8);
    endtask : wr1
    task wr2(input logic [15:0] w, output logic [15:0] rd);
        host_u.frame2(w, rd);
        tick(8);
    endtask : wr2
    task put(input logic [11:0] s, input logic b, input logic t);
        SAMPLE = s;
        SAMPLE_BIPOLAR = b;
        SAMPLE_TEMP = t;
        SAMPLE_VALID = 1'b1;
        tick(1);
        SAMPLE_VALID = 1'b0;
        tick(6);
    endtask : put
    function logic [31:0] cfg();
        return {4'h0, CLOCK_MODE, VREF_MODE, UNI_PAIR_ENABLE, BI_PAIR_ENABLE,
            AVERAGE_ENABLE, CONV_CHANNEL, CONV_SCAN, CONV_TEMP};
    endfunction : cfg
    function logic [31:0] dflt();
        return {4'h0, CLK_INT_SERIAL, VREF_INT_WAKE, PAIR_RESET, PAIR_RESET,
            1'b0, 4'h0, 2'h0, 1'b0};
    endfunction : dflt
    function logic [5:0] exp_avg(input logic [4:0] a);
        return a[4] ? AVG_BASE << a[3:2] : AVG_ONE;
    endfunction : exp_avg
    function logic [4:0] exp_rep(input logic [1:0] sc, input logic [1:0] n);
        return sc == SCAN_REPEAT ? 5'({n, 2'b00}) + REPEAT_STEP : 5'h00;
    endfunction : exp_rep
    initial begin
        #1ms;
        n_fail++;
        final_report();
    end
    initial begin
        logic [7:0] b, c, d, u, bi;
        logic [15:0] rd;
        logic [11:0] s, s2;
        logic [31:0] snap;
        int n0;
        b = 8'($urandom(32'h1b9e));
        u = 8'h00;
        bi = 8'h00;
        tick(3);
        RST = 1'b0;
        tick(3);
        chk(cfg(), dflt(), "reset");
        chk(AVG_CONVERSIONS, AVG_ONE, "reset avg");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            b = {2'b01, i[3:0], 1'b0, 1'($urandom)};
            wr1(b);
            chk({CLOCK_MODE, VREF_MODE}, b[5:2], "setup");
            chk({UNI_PAIR_ENABLE, BI_PAIR_ENABLE}, 0, "pairs kept");
        end
        $display("test setup done");
        for (int i = 0; i < 4; i++) begin
            d = (i == 1) ? 8'h05 : 8'($urandom);
            if (i[0]) bi = d;
            else u = d;
            wr2({8'h62 | 8'(i[0]), d}, rd);
            chk(UNI_PAIR_ENABLE, u, "uni");
            chk(BI_PAIR_ENABLE, bi, "bi");
            chk(BI_PAIR_EFFECTIVE, bi & ~u, "eff");
        end
        wr2(16'h6135, rd);
        chk({UNI_PAIR_ENABLE, AVG_CONVERSIONS}, {u, 6'h08}, "next");
        $display("test pairing done");
        for (int i = 0; i < 8; i++) begin
            b = {3'b001, i[2:0], 2'($urandom)};
            wr1(b);
            chk(AVERAGE_ENABLE, b[4], "avg on");
            chk(AVG_CONVERSIONS, exp_avg(b[4:0]), "avg n");
            for (int j = 0; j < 4; j++) begin
                c = {1'b1, 4'($urandom), j[1:0], 1'($urandom)};
                n0 = n_start;
                wr1(c);
                snap = {4'h0, CLK_INT_SERIAL, VREF_INT_WAKE, u, bi, b[4],
                    c[6:0]};
                chk(cfg(), snap, "conv");
                chk(REPEAT_RESULTS, exp_rep(j[1:0], b[1:0]), "rep");
                chk(n_start - n0, 1, "serial start");
            end
        end
        for (int m = 0; m < 3; m++) begin
            c = {2'b01, 1'(m == 0), 1'(m != 1), 4'h0};
            wr1(c);
            chk(AVG_CONVERSIONS, m ? exp_avg(b[4:0]) : AVG_ONE, "m");
            n0 = n_start;
            wr1(8'h80);
            chk(n_start - n0, m == 0, "byte start");
            CONVERT_START_PIN_N = 1'b0;
            tick(3);
            CONVERT_START_PIN_N = 1'b1;
            tick(8);
            chk(n_start - n0, 1, "pin start");
        end
        $display("test conversion done");
        snap = cfg();
        wr1({4'h0, 4'($urandom)});
        chk(cfg(), snap, "nop");
        n0 = n_clear;
        wr1({5'b00011, 3'($urandom)});
        chk(cfg(), snap, "fifo only");
        wr1({5'b00010, 3'($urandom)});
        chk(cfg(), dflt(), "full reset");
        chk(n_clear - n0, 2, "clears");
        $display("test reset command done");
        for (int i = 0; i < 6; i++) begin
            s = 12'($urandom);
            put(s, i[0], 1'b0);
            wr2(16'h0000, rd);
            chk(rd, {4'h0, s ^ {i[0], 11'h000}}, "result");
        end
        s = 12'($urandom);
        s2 = 12'($urandom);
        put(s, 1'b0, 1'b1);
        put(s2, 1'b0, 1'b1);
        wr2(16'h0000, rd);
        chk(rd, {4'h0, s - s2 - T_OFF}, "temp");
        $display("test results done");
        final_report();
    end
endmodule : asc_config_test
